// File: design/csr_status_top.sv
// csr_status_top: per-channel status reporting with live, history and serial poll answers
// assumes condition pins are asynchronous; queries come from the command decoder on clk_sys
//
// How it works
// - eight-bit live register per channel
// - live bit set while condition holds
// - low bits: voltage, +current, -current, overvoltage
// - bit five flags unregulated, weight 32
// - bits four, six, seven: temp, overcurrent, coupled
// - answer is weighted sum, 0 to 255
// - range change or power limit sets coupled
// - no-change setting clears coupled bit
// - history register keeps every condition since read
// - history read reloads from live value
// - one shared serial poll register
// - live register not writable by controller
`timescale 1ns/1ps
module csr_status_top
  import csr_pkg::*;
#(
  parameter int CHANNELS = CSR_CHANNELS
)(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [CHANNELS*7-1:0] cond_pins,
  input wire logic [CHANNELS-1:0] cp_set,
  input wire logic [CHANNELS-1:0] cp_clear,
  input wire logic [3:0] poll_upper,
  input wire logic query_valid,
  input wire logic [1:0] query_kind,
  input wire logic [CSR_CH_W-1:0] query_channel,
  output logic [7:0] answer_reg,
  output logic answer_valid_reg
);
  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [CHANNELS*7-1:0] cond_meta_reg;
  logic [CHANNELS*7-1:0] cond_sync_reg;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cond_meta_reg <= '0;
      cond_sync_reg <= '0;
    end else begin
      cond_meta_reg <= cond_pins;
      cond_sync_reg <= cond_meta_reg;
    end
  end

  // ---------------------------------------------------------------
  // channels
  // ---------------------------------------------------------------
  logic [7:0] live_all [CHANNELS];
  logic [7:0] hist_all [CHANNELS];
  logic [CHANNELS-1:0] hist_read;
  logic [CHANNELS-1:0] any_live;

  // the channel must be named: no broadcast read exists
  generate
    for (genvar c = 0; c < CHANNELS; c++) begin : g_ch
      assign hist_read[c] = query_valid && (query_kind == CSR_Q_HISTORY)
                            && (query_channel == CSR_CH_W'(c));
      assign any_live[c] = |live_all[c];
      csr_channel u_ch (
        .clk_sys(clk_sys),
        .reset(reset),
        .cond_in(cond_sync_reg[c*7 +: 7]),
        .cp_set(cp_set[c]),
        .cp_clear(cp_clear[c]),
        .history_read(hist_read[c]),
        .live_reg(live_all[c]),
        .history_reg(hist_all[c])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // answer selection
  // ---------------------------------------------------------------
  logic [7:0] poll_value;
  logic [3:0] fault_summary;
  logic [7:0] answer_next;
  logic ch_ok;

  // low nibble shows which channels have any condition, upper supplied by the controller core
  assign fault_summary = 4'(any_live);
  assign poll_value = {poll_upper, fault_summary};
  assign ch_ok = 32'(query_channel) < CHANNELS;

  // binary value equals the sum of bit weights
  always_comb begin
    answer_next = CSR_RESET_VALUE;
    case (query_kind)
      CSR_Q_LIVE: answer_next = ch_ok ? live_all[query_channel] : CSR_RESET_VALUE;
      CSR_Q_HISTORY: answer_next = ch_ok ? hist_all[query_channel] : CSR_RESET_VALUE;
      CSR_Q_POLL: answer_next = poll_value;
      default: answer_next = CSR_RESET_VALUE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      answer_reg <= CSR_RESET_VALUE;
      answer_valid_reg <= 1'b0;
    end else begin
      answer_valid_reg <= query_valid && (query_kind != CSR_Q_NONE);
      if (query_valid) begin
        answer_reg <= answer_next;
      end
    end
  end

  a_answer_pulse: assert property (@(posedge clk_sys) disable iff (reset)
    (query_valid && query_kind == CSR_Q_POLL) |=> (answer_valid_reg && answer_reg[7:4] ==
    $past(poll_upper))) else $error("poll answer wrong");
  a_live_answer: assert property (@(posedge clk_sys) disable iff (reset)
    (query_valid && query_kind == CSR_Q_LIVE && query_channel == 2'h0) |=>
    (answer_reg == $past(live_all[0]))) else $error("live answer wrong");

  // ---------------------------------------------------------------
  // query decode for the checks
  // ---------------------------------------------------------------
  logic q_live;
  logic q_hist;
  logic q_poll;
  logic q_none;
  logic q_answered;

  // named decode keeps the properties short
  assign q_live = query_valid && (query_kind == CSR_Q_LIVE);
  assign q_hist = query_valid && (query_kind == CSR_Q_HISTORY);
  assign q_poll = query_valid && (query_kind == CSR_Q_POLL);
  assign q_none = query_valid && (query_kind == CSR_Q_NONE);
  assign q_answered = q_live || q_hist || q_poll;

  // ---------------------------------------------------------------
  // answer port, history reload and synchroniser checks
  // ---------------------------------------------------------------
  // the answer properties lean on the one-edge answer latency; the hist_read checks are same-cycle
  a_reset_quiet: assert property (@(posedge clk_sys)
    reset |=> (answer_reg == CSR_RESET_VALUE && !answer_valid_reg))
    else $error("answer not quiet after reset");

  a_valid_on_query: assert property (@(posedge clk_sys) disable iff (reset)
    q_answered |=> answer_valid_reg)
    else $error("answer valid missing");

  a_none_silent: assert property (@(posedge clk_sys) disable iff (reset)
    q_none |=> !answer_valid_reg)
    else $error("valid raised for empty query");

  a_none_zero: assert property (@(posedge clk_sys) disable iff (reset)
    q_none |=> (answer_reg == CSR_RESET_VALUE))
    else $error("empty query left a value");

  a_idle_silent: assert property (@(posedge clk_sys) disable iff (reset)
    !query_valid |=> !answer_valid_reg)
    else $error("valid raised without a query");

  a_answer_holds: assert property (@(posedge clk_sys) disable iff (reset)
    !query_valid |=> $stable(answer_reg))
    else $error("answer moved without a query");

  a_poll_low: assert property (@(posedge clk_sys) disable iff (reset)
    q_poll |=> (answer_reg[3:0] == $past(fault_summary)))
    else $error("poll channel bits wrong");

  a_poll_whole: assert property (@(posedge clk_sys) disable iff (reset)
    q_poll |=> (answer_reg == $past(poll_value)))
    else $error("poll answer not the shared register");

  a_hist_read_single: assert property (@(posedge clk_sys) disable iff (reset)
    $onehot0(hist_read))
    else $error("more than one history reload");

  a_hist_read_sel: assert property (@(posedge clk_sys) disable iff (reset)
    (q_hist && ch_ok) |-> (hist_read != '0))
    else $error("history query did not reload");

  a_no_hist_idle: assert property (@(posedge clk_sys) disable iff (reset)
    !q_hist |-> (hist_read == '0))
    else $error("history reloaded without its query");

  a_meta_follows: assert property (@(posedge clk_sys) disable iff (reset)
    1'b1 |=> (cond_meta_reg == $past(cond_pins)))
    else $error("first sync stage not tracking");

  a_sync_follows: assert property (@(posedge clk_sys) disable iff (reset)
    1'b1 |=> (cond_sync_reg == $past(cond_meta_reg)))
    else $error("second sync stage not tracking");

  a_sync_reset: assert property (@(posedge clk_sys)
    reset |=> (cond_sync_reg == '0))
    else $error("sync stage not cleared by reset");

  // ---------------------------------------------------------------
  // per-channel checks
  // ---------------------------------------------------------------
  // the live register is fed by the conditions and cp_set/cp_clear only; queries never write it
  generate
    for (genvar k = 0; k < CHANNELS; k++) begin : g_chk
      a_live_of_ch: assert property (@(posedge clk_sys) disable iff (reset)
        (q_live && query_channel == CSR_CH_W'(k)) |=> (answer_reg == $past(live_all[k])))
        else $error("live answer of channel wrong");

      a_hist_of_ch: assert property (@(posedge clk_sys) disable iff (reset)
        (q_hist && query_channel == CSR_CH_W'(k)) |=> (answer_reg == $past(hist_all[k])))
        else $error("history answer of channel wrong");

      a_live_no_write: assert property (@(posedge clk_sys) disable iff (reset)
        (query_valid && $stable(cond_sync_reg) && !cp_set[k] && !cp_clear[k]) |=>
        $stable(live_all[k]))
        else $error("live register moved by a query");

      a_cp_held: assert property (@(posedge clk_sys) disable iff (reset)
        (!cp_set[k] && !cp_clear[k]) |=>
        (live_all[k][CSR_BIT_CP] == $past(live_all[k][CSR_BIT_CP])))
        else $error("coupled bit moved without a cause");
    end
  endgenerate
endmodule : csr_status_top

// File: design/csr_pkg.sv
// csr_pkg: bit layout, query codes and sizes for the channel status reporting block
// assumes one system clock; all users import csr_pkg::*
package csr_pkg;
  localparam int CSR_CHANNELS = 4;
  localparam int CSR_WIDTH = 8;
  localparam int CSR_CH_W = 2;
  // bit positions of the condition registers; weight of bit n is 2**n
  localparam int CSR_BIT_CV = 0;
  localparam int CSR_BIT_POS_CC = 1;
  localparam int CSR_BIT_NEG_CC = 2;
  localparam int CSR_BIT_OV = 3;
  localparam int CSR_BIT_OT = 4;
  localparam int CSR_BIT_UNR = 5;
  localparam int CSR_BIT_OC = 6;
  localparam int CSR_BIT_CP = 7;
  localparam logic [7:0] CSR_RESET_VALUE = 8'h00;
  // query selector on the command port
  typedef enum logic [1:0] {
    CSR_Q_LIVE = 2'b00,
    CSR_Q_HISTORY = 2'b01,
    CSR_Q_POLL = 2'b10,
    CSR_Q_NONE = 2'b11
  } csr_query_t;
endpackage : csr_pkg

// File: design/csr_channel.sv
// csr_channel: live and accumulated condition registers of one output channel
// assumes condition inputs already synchronised to clk_sys by the top
`timescale 1ns/1ps
module csr_channel
  import csr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [6:0] cond_in,
  input wire logic cp_set,
  input wire logic cp_clear,
  input wire logic history_read,
  output logic [7:0] live_reg,
  output logic [7:0] history_reg
);
  logic [7:0] live_next;
  logic [7:0] history_next;
  logic cp_next;

  // set beats clear when both arrive together
  assign cp_next = cp_set ? 1'b1 : (cp_clear ? 1'b0 : live_reg[CSR_BIT_CP]);
  assign live_next = {cp_next, cond_in};
  // a read reloads from the live value, not zero, so ongoing conditions stay visible
  assign history_next = history_read ? live_next : (history_reg | live_next);

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      live_reg <= CSR_RESET_VALUE;
      history_reg <= CSR_RESET_VALUE;
    end else begin
      live_reg <= live_next;
      history_reg <= history_next;
    end
  end

  a_history_holds_live: assert property (@(posedge clk_sys) disable iff (reset)
    ((live_reg & ~history_reg) == 8'h00)) else $error("history lost a live bit");
  a_history_reload: assert property (@(posedge clk_sys) disable iff (reset)
    history_read |=> (history_reg == live_reg)) else $error("history not reloaded");
  a_history_sticky: assert property (@(posedge clk_sys) disable iff (reset)
    !history_read |=> ((($past(history_reg)) & ~history_reg) == 8'h00))
    else $error("history bit dropped between reads");
  a_cp_set_wins: assert property (@(posedge clk_sys) disable iff (reset)
    cp_set |=> live_reg[CSR_BIT_CP]) else $error("coupled bit not set");
  a_cp_clears: assert property (@(posedge clk_sys) disable iff (reset)
    (cp_clear && !cp_set) |=> !live_reg[CSR_BIT_CP]) else $error("coupled bit not cleared");
  a_live_follows: assert property (@(posedge clk_sys) disable iff (reset)
    1'b1 |=> (live_reg[6:0] == $past(cond_in))) else $error("live bits not tracking");
endmodule : csr_channel

// File: tb/csr_ctrl_model.sv
// csr_ctrl_model: remote controller that sends channel-addressed queries
// assumes ask is called just after a rising clk_sys edge
`timescale 1ns/1ps
module csr_ctrl_model (
  input wire logic clk_sys,
  output logic query_valid,
  output logic [1:0] query_kind,
  output logic [1:0] query_channel
);
  initial begin
    query_valid = 1'b0;
    query_kind = 2'h3;
    query_channel = 2'h0;
  end
  task automatic ask(input logic [1:0] kind, input logic [1:0] ch);
    @(posedge clk_sys);
    query_valid <= 1'b1;
    query_kind <= kind;
    query_channel <= ch;
    @(posedge clk_sys);
    query_valid <= 1'b0;
    // the idle channel line carries junk, never a stale channel; query_kind keeps its last code
    query_channel <= ~ch;
  endtask : ask
endmodule : csr_ctrl_model

// File: tb/channel_status_reporting_bench.sv
// channel_status_reporting_bench: self-checking bench of csr_status_top
// assumes answers come exactly one edge after the query is taken
`timescale 1ns/1ps
module channel_status_reporting_bench;
  import csr_pkg::*;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [27:0] cond_pins = 28'h0;
  logic [3:0] cp_set = 4'h0;
  logic [3:0] cp_clear = 4'h0;
  logic [3:0] poll_upper = 4'h5;
  logic query_valid;
  logic answer_valid_reg;
  logic [1:0] query_kind;
  logic [1:0] query_channel;
  logic [7:0] answer_reg;
  int fail_count = 0;
  int check_count = 0;
  int cycles = 0;
  always #25 clk_sys = ~clk_sys;
  csr_ctrl_model ctrl (.clk_sys(clk_sys), .query_valid(query_valid),
    .query_kind(query_kind), .query_channel(query_channel));
  csr_status_top #(.CHANNELS(4)) uut (.clk_sys(clk_sys), .reset(reset),
    .cond_pins(cond_pins), .cp_set(cp_set), .cp_clear(cp_clear),
    .poll_upper(poll_upper), .query_valid(query_valid), .query_kind(query_kind),
    .query_channel(query_channel), .answer_reg(answer_reg),
    .answer_valid_reg(answer_valid_reg));
  // ----------------------------------------
  // shared checks
  // ----------------------------------------
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic ask_chk(input logic [1:0] kind, input logic [1:0] ch,
    input logic [7:0] exp);
    ctrl.ask(kind, ch);
    #1;
    chk("answer_valid_reg", 8'h01, {7'h00, answer_valid_reg});
    chk("answer_reg", exp, answer_reg);
  endtask : ask_chk
  task automatic settle();
    // two sync stages plus the register, one spare
    repeat (4) @(posedge clk_sys);
  endtask : settle
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_live();
    cond_pins <= {7'h0F, 7'h00, 7'h20, 7'h50};
    settle();
    ask_chk(CSR_Q_LIVE, 2'h1, 8'h20);
    ask_chk(CSR_Q_LIVE, 2'h3, 8'h0F);
    ask_chk(CSR_Q_LIVE, 2'h0, 8'h50);
    ask_chk(CSR_Q_POLL, 2'h0, 8'h5B);
  endtask : t_live
  task automatic t_hist();
    cond_pins[20:14] <= 7'h08;
    settle();
    cond_pins[20:14] <= 7'h01;
    settle();
    ask_chk(CSR_Q_HISTORY, 2'h2, 8'h09);
    ask_chk(CSR_Q_HISTORY, 2'h2, 8'h01);
    ask_chk(CSR_Q_LIVE, 2'h2, 8'h01);
  endtask : t_hist
  task automatic t_coupled();
    cond_pins[13:7] <= 7'h7F;
    cp_set <= 4'h3;
    @(posedge clk_sys);
    cp_set <= 4'h0;
    settle();
    ask_chk(CSR_Q_LIVE, 2'h0, 8'hD0);
    ask_chk(CSR_Q_LIVE, 2'h1, 8'hFF);
    cp_clear <= 4'h1;
    @(posedge clk_sys);
    cp_clear <= 4'h0;
    ask_chk(CSR_Q_LIVE, 2'h0, 8'h50);
  endtask : t_coupled
  task automatic t_none();
    ctrl.ask(CSR_Q_NONE, 2'h0);
    #1;
    chk("answer_valid_reg", 8'h00, {7'h00, answer_valid_reg});
  endtask : t_none
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      fail_count++;
      stop_test();
    end
  end
  initial begin
    repeat (20) @(posedge clk_sys);
    chk("answer_reg in reset", 8'h00, answer_reg);
    reset <= 1'b0;
    t_live();
    t_hist();
    t_coupled();
    t_none();
    stop_test();
  end
endmodule : channel_status_reporting_bench
